// ===== pftb_top.sv
`timescale 1ns/100ps
module pftb_top
  import pftb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Avalon-MM register slave.
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  // Execution trace interface.
  input  wire logic        trc_valid,
  input  wire logic        trc_branch,
  input  wire logic        trc_exception,
  input  wire logic [31:0] trc_src_pc,
  input  wire logic [31:0] trc_dst_pc,
  output logic             trc_ready,
  // Processor / debug port into the shared SRAM.
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [PFTB_AW-1:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_gnt,
  output logic [31:0]      cpu_rdata,
  output logic             cpu_rvalid,
  output logic             halt_req
);

  // ---------------------------------------------------------------------------
  // State and registers
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PFTB_ST_IDLE  = 3'b001,
    PFTB_ST_WORD0 = 3'b010,
    PFTB_ST_WORD1 = 3'b100
  } pftb_state_t;

  pftb_state_t      state_reg;
  pftb_state_t      state_next;
  logic [31:0]      master_reg;
  logic [31:0]      flow_reg;
  logic [PFTB_AW-1:0] ptr_reg;
  logic             wrap_reg;
  logic             halt_reg;
  logic             rd_pend_reg;
  logic [31:0]      rdata_reg;
  logic             cpu_rv_reg;

  // Buffer placement: low bits of the master register give the size as a
  // power of two (bytes = 2^(size+4)), base comes from the position field
  // masked by that size.
  wire [3:0] size_sel = master_reg[3:0];
  wire [PFTB_AW-1:0] buf_mask =
    PFTB_AW'((32'd16 << size_sel) - 32'd1);
  wire trace_en = master_reg[PFTB_MST_EN_BIT];

  // ---------------------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------------------
  wire        in_window =
    (avs_address[31:4] == PFTB_REG_BASE_ADDR[31:4]);
  wire [3:0]  ofs       = avs_address[3:0];
  wire        hit_pos   = in_window && ofs == PFTB_OFS_POSITION;
  wire        hit_mst   = in_window && ofs == PFTB_OFS_MASTER;
  wire        hit_flow  = in_window && ofs == PFTB_OFS_FLOW;
  wire        hit_base  = in_window && ofs == PFTB_OFS_BASE;
  wire        hit_any   = hit_pos || hit_mst || hit_flow || hit_base;
  wire        wr_acc    = avs_write && !avs_waitrequest;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  wire [31:0] pos_view = {{(32-PFTB_AW){1'b0}}, ptr_reg[PFTB_AW-1:3],
                          wrap_reg, 2'b00};
  wire [31:0] rd_mux =
    hit_pos  ? pos_view :
    hit_mst  ? master_reg :
    hit_flow ? flow_reg :
    hit_base ? PFTB_SRAM_BASE : 32'h0000_0000;

  // Reads take one wait cycle, writes none.
  assign avs_waitrequest = avs_read && !rd_pend_reg;
  assign avs_response    = hit_any ? 2'b00 : 2'b10;
  assign avs_readdata    = rdata_reg;

  // ---------------------------------------------------------------------------
  // Packet capture and SRAM arbitration
  // ---------------------------------------------------------------------------
  wire       nonseq    = trc_branch || trc_exception;
  wire       cap_valid = trc_valid && nonseq && trace_en;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_out_ready;
  pftb_pkt_t fifo_out;
  pftb_pkt_t cap_pkt;

  assign cap_pkt   = '{src: trc_src_pc, dst: trc_dst_pc};
  assign trc_ready = fifo_in_ready || !(nonseq && trace_en);

  pftb_fifo #(
    .WIDTH ($bits(pftb_pkt_t)),
    .DEPTH (PFTB_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (cap_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (cap_pkt),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  wire trace_wr   = (state_reg != PFTB_ST_IDLE);
  wire [PFTB_AW-1:0] buf_base = ptr_reg & ~buf_mask;
  wire [PFTB_AW-1:0] ptr_adv  = PFTB_AW'(ptr_reg + PFTB_PKT_BYTES);
  wire [PFTB_AW-1:0] ptr_wrapd =
    buf_base | (ptr_adv & buf_mask);
  wire wraps      = (ptr_adv & buf_mask) == '0;
  wire [PFTB_AW-1:0] wmark = flow_reg[PFTB_AW-1:0] & ~PFTB_AW'(3'h7);
  wire at_wmark   = (ptr_wrapd == wmark);

  assign fifo_out_ready = (state_reg == PFTB_ST_WORD1);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PFTB_ST_IDLE:  if (fifo_out_valid) state_next = PFTB_ST_WORD0;
      PFTB_ST_WORD0: state_next = PFTB_ST_WORD1;
      PFTB_ST_WORD1: state_next = PFTB_ST_IDLE;
    endcase
  end

  pftb_sram_req_t sram_req;
  logic [31:0]    sram_rdata;

  always_comb begin
    sram_req = '0;
    if (trace_wr) begin
      sram_req.req   = 1'b1;
      sram_req.we    = 1'b1;
      sram_req.addr  = (state_reg == PFTB_ST_WORD0) ? ptr_reg
                                                    : ptr_reg | PFTB_AW'(3'h4);
      sram_req.wdata = (state_reg == PFTB_ST_WORD0) ? fifo_out.src
                                                    : fifo_out.dst;
    end else if (cpu_req) begin
      sram_req.req   = 1'b1;
      sram_req.we    = cpu_we;
      sram_req.addr  = cpu_addr;
      sram_req.wdata = cpu_wdata;
    end
  end

  assign cpu_gnt   = cpu_req && !trace_wr;
  assign cpu_rdata = sram_rdata;
  assign cpu_rvalid = cpu_rv_reg;
  assign halt_req  = halt_reg;

  pftb_sram u_sram (
    .sys_clk  (sys_clk),
    .port_req (sram_req),
    .rdata    (sram_rdata)
  );

  // ---------------------------------------------------------------------------
  // Sequential logic
  // ---------------------------------------------------------------------------
  wire pkt_done  = (state_reg == PFTB_ST_WORD1);
  wire stop_hit  = pkt_done && at_wmark &&
                   flow_reg[PFTB_FLOW_STOP_BIT];
  wire halt_hit  = pkt_done && at_wmark &&
                   flow_reg[PFTB_FLOW_HALT_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= PFTB_ST_IDLE;
      rd_pend_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      cpu_rv_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      rd_pend_reg <= avs_read && !rd_pend_reg;
      cpu_rv_reg  <= cpu_gnt && !cpu_we;
      if (avs_read && !rd_pend_reg) rdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      master_reg <= PFTB_MASTER_RST;
      flow_reg   <= PFTB_FLOW_RST;
      halt_reg   <= 1'b0;
    end else begin
      if (wr_acc && hit_mst) begin
        master_reg <= be_merge(master_reg, avs_writedata,
                               avs_byteenable);
      end else if (stop_hit) begin
        master_reg[PFTB_MST_EN_BIT] <= 1'b0;
      end
      if (wr_acc && hit_flow) begin
        flow_reg <= be_merge(flow_reg, avs_writedata,
                             avs_byteenable);
      end
      if (halt_hit) begin
        halt_reg <= 1'b1;
      end else if (wr_acc && hit_mst) begin
        halt_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg  <= PFTB_POS_RST[PFTB_AW-1:0];
      wrap_reg <= 1'b0;
    end else if (pkt_done) begin
      ptr_reg  <= ptr_wrapd;
      if (wraps) wrap_reg <= 1'b1;
    end else if (wr_acc && hit_pos) begin
      ptr_reg  <= {avs_writedata[PFTB_AW-1:3], 3'b000};
      wrap_reg <= avs_writedata[PFTB_POS_WRAP_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_trace_prio;
    @(posedge sys_clk) disable iff (!rst_b)
      trace_wr |-> !cpu_gnt && sram_req.we;
  endproperty
  a_trace_prio: assert property (p_trace_prio)
    else $error("cpu granted during trace write");

  property p_two_words;
    @(posedge sys_clk) disable iff (!rst_b)
      (state_reg == PFTB_ST_WORD0) |=> (state_reg == PFTB_ST_WORD1)
        ##1 (state_reg == PFTB_ST_IDLE);
  endproperty
  a_two_words: assert property (p_two_words)
    else $error("packet not two words");

  property p_advance;
    @(posedge sys_clk) disable iff (!rst_b)
      pkt_done |=> ptr_reg == $past(ptr_wrapd);
  endproperty
  a_advance: assert property (p_advance)
    else $error("pointer did not advance");

  property p_wrap_flag;
    @(posedge sys_clk) disable iff (!rst_b)
      (pkt_done && wraps) |=> wrap_reg && ptr_reg == $past(buf_base);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap not flagged");

  property p_stop_on_watermark;
    @(posedge sys_clk) disable iff (!rst_b)
      (stop_hit && !(wr_acc && hit_mst)) |=> !trace_en;
  endproperty
  a_stop_on_watermark: assert property (p_stop_on_watermark)
    else $error("trace did not stop at watermark");

  property p_capture;
    @(posedge sys_clk) disable iff (!rst_b)
      (cap_valid && fifo_in_ready && state_reg == PFTB_ST_IDLE
       && !fifo_out_valid) |=> ##1 (state_reg == PFTB_ST_WORD0);
  endproperty
  a_capture: assert property (p_capture)
    else $error("packet not written");

  property p_disabled;
    @(posedge sys_clk) disable iff (!rst_b)
      (!trace_en && !fifo_out_valid) |=> !fifo_out_valid;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("capture while disabled");

  property p_base_ro;
    @(posedge sys_clk) disable iff (!rst_b)
      (avs_read && hit_base && !rd_pend_reg) |=>
        avs_readdata == PFTB_SRAM_BASE;
  endproperty
  a_base_ro: assert property (p_base_ro)
    else $error("base register wrong");

  property p_halt;
    @(posedge sys_clk) disable iff (!rst_b)
      halt_hit |=> halt_req;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt not requested at watermark");
endmodule

// ===== pftb_pkg.sv
// What this block does
// - While enabled, record program flow changes as packets in SRAM.
// - Trace SRAM writes win over processor accesses; the processor waits.
// - Each non-sequential PC change emits one packet of two 32-bit words.
// - Taken branches and exception entries count as non-sequential changes.
// - Tracing runs only while control enable bit is 1; writes start/stop.
// - With stop set, tracing ends when the pointer reaches the watermark.
// - Without watermark stop, a full buffer wraps over the oldest packets.
// - Registers decode at fixed offsets from base address 0x41006000.
// - Position register holds write pointer and a wrap flag.
// - Flow register holds watermark plus stop and halt selection bits.
// - Read-only base register reports trace SRAM location in memory map.
// - Processor may use trace SRAM as storage while tracing goes on.
// - Software configures trace buffer position and size within SRAM.
package pftb_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PFTB_REG_BASE_ADDR = 32'h4100_6000;
  localparam logic [3:0]  PFTB_OFS_POSITION  = 4'h0;
  localparam logic [3:0]  PFTB_OFS_MASTER    = 4'h4;
  localparam logic [3:0]  PFTB_OFS_FLOW      = 4'h8;
  localparam logic [3:0]  PFTB_OFS_BASE      = 4'hC;
  localparam logic [31:0] PFTB_SRAM_BASE     = 32'h2000_0000;
  localparam int          PFTB_AW            = 13;
  localparam int          PFTB_WORDS         = 2048;

  // Field positions.
  localparam int PFTB_POS_WRAP_BIT   = 2;
  localparam int PFTB_MST_EN_BIT     = 31;
  localparam int PFTB_MST_HALTREQ    = 9;
  localparam int PFTB_FLOW_STOP_BIT  = 0;
  localparam int PFTB_FLOW_HALT_BIT  = 1;

  // Reset values.
  localparam logic [31:0] PFTB_MASTER_RST  = 32'h0000_0000;
  localparam logic [31:0] PFTB_FLOW_RST    = 32'h0000_0000;
  localparam logic [31:0] PFTB_POS_RST     = 32'h0000_0000;
  localparam logic [3:0]  PFTB_MASK_RST    = 4'h0;

  localparam logic [PFTB_AW-1:0] PFTB_PKT_BYTES = 13'h0008;
  localparam int                 PFTB_FIFO_DEPTH = 4;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
  } pftb_pkt_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [PFTB_AW-1:0] addr;
    logic [31:0] wdata;
  } pftb_sram_req_t;

endpackage

// ===== pftb_fifo.sv
`timescale 1ns/100ps
module pftb_fifo
  import pftb_pkg::*;
#(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= PW'(wr_ptr_reg + 1'b1);
      if (pop)  rd_ptr_reg <= PW'(rd_ptr_reg + 1'b1);
      count_reg <= (PW+1)'(count_reg + push - pop);
    end
  end

  property p_no_overflow;
    @(posedge sys_clk) disable iff (!rst_b)
      (count_reg == (PW+1)'(DEPTH)) |->
        !in_ready && (wr_ptr_reg == rd_ptr_reg);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("fifo ready while full");
endmodule

// ===== pftb_sram.sv
`timescale 1ns/100ps
module pftb_sram
  import pftb_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire pftb_sram_req_t port_req,
  output logic [31:0]         rdata
);
  logic [31:0] mem [PFTB_WORDS];
  wire  [PFTB_AW-3:0] widx = port_req.addr[PFTB_AW-1:2];

  always_ff @(posedge sys_clk) begin
    if (port_req.req && port_req.we) begin
      mem[widx] <= port_req.wdata;
    end
    rdata <= mem[widx];
  end
endmodule

// ===== pftb_trace_src.sv
`timescale 1ns/100ps
module pftb_trace_src
  import pftb_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  trc_ready,
  output logic       trc_valid,
  output logic       trc_branch,
  output logic       trc_exception,
  output logic [31:0] trc_src_pc,
  output logic [31:0] trc_dst_pc
);
  // ---------------------------------------------------------------------
  // Processor trace source
  // ---------------------------------------------------------------------
  int n_refused = 0;

  initial begin
    trc_valid     = 1'h0;
    trc_branch    = 1'h0;
    trc_exception = 1'h0;
    trc_src_pc    = 32'h0000_0000;
    trc_dst_pc    = 32'h0000_0000;
  end

  // Hold keeps the event up so a following call streams back to back.
  // Released lines show inverted data so nothing stale looks valid.
  task automatic send(input logic [31:0] s, input logic [31:0] d,
                      input logic br, input logic ex, input bit hold);
    logic r;
    trc_valid     <= 1'h1;
    trc_src_pc    <= s;
    trc_dst_pc    <= d;
    trc_branch    <= br;
    trc_exception <= ex;
    do begin
      @(posedge sys_clk);
      r = trc_ready;
      if (r !== 1'h1) n_refused++;
    end while (r !== 1'h1);
    if (!hold) begin
      trc_valid     <= 1'h0;
      trc_src_pc    <= ~s;
      trc_dst_pc    <= ~d;
      trc_branch    <= ~br;
      trc_exception <= ~ex;
    end
  endtask
endmodule

// ===== pftb_tb_top.sv
`timescale 1ns/100ps
module pftb_tb_top;
  import pftb_pkg::*;
  // ---------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_address, avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rsp;
  logic trc_valid, trc_branch, trc_exception, trc_ready;
  logic [31:0] trc_src_pc, trc_dst_pc, cpu_wdata, cpu_rdata;
  logic cpu_req, cpu_we, cpu_gnt, cpu_rvalid, halt_req;
  logic [PFTB_AW-1:0] cpu_addr;
  int n_mismatch = 0;
  int checks = 0;
  int n_blk = 0;
  int i;

  pftb_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .trc_valid(trc_valid), .trc_branch(trc_branch),
    .trc_exception(trc_exception), .trc_src_pc(trc_src_pc),
    .trc_dst_pc(trc_dst_pc), .trc_ready(trc_ready),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_gnt(cpu_gnt), .cpu_rdata(cpu_rdata),
    .cpu_rvalid(cpu_rvalid), .halt_req(halt_req));

  pftb_trace_src i_src (.sys_clk(sys_clk), .trc_ready(trc_ready),
    .trc_valid(trc_valid), .trc_branch(trc_branch),
    .trc_exception(trc_exception), .trc_src_pc(trc_src_pc),
    .trc_dst_pc(trc_dst_pc));

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (cpu_req === 1'h1 && cpu_gnt !== 1'h1) n_blk++;
  end

  // The whole sequence needs a few hundred cycles; this is ample margin.
  initial begin
    #200_000;
    n_mismatch++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] ofs,
                     input logic [31:0] d);
    logic w;
    @(posedge sys_clk);
    avs_address   <= PFTB_REG_BASE_ADDR + {24'h00_0000, ofs};
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge sys_clk);
      w   = avs_waitrequest;
      q   = avs_readdata;
      rsp = avs_response;
    end while (w !== 1'h0);
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [31:0] exp,
                    input string nm);
    bus(1'h0, ofs, 32'h0000_0000);
    check(nm, q, exp);
  endtask

  task automatic cpu(input logic we, input logic [12:0] a,
                     input logic [31:0] d);
    logic g;
    @(posedge sys_clk);
    cpu_req   <= 1'h1;
    cpu_we    <= we;
    cpu_addr  <= a;
    cpu_wdata <= d;
    do begin
      @(posedge sys_clk);
      g = cpu_gnt;
    end while (g !== 1'h1);
    cpu_req <= 1'h0;
    @(posedge sys_clk);
    if (!we) begin
      check("cpu_rvalid", 32'(cpu_rvalid), 32'h1);
      q = cpu_rdata;
    end
  endtask

  task automatic wait_pos(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'h0, 8'h00, 32'h0000_0000);
      n++;
    end while (q !== exp && n < 40);
    check("position", q, exp);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    {avs_read, avs_write, cpu_req, cpu_we} = 4'h0;
    avs_address = 32'h0000_0000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    cpu_addr = 13'h0000;
    cpu_wdata = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'h1;
    rd(8'h00, 32'h0000_0000, "position");
    rd(8'h04, 32'h0000_0000, "master");
    rd(8'h08, 32'h0000_0000, "flow");
    rd(8'h0C, PFTB_SRAM_BASE, "base");
    check("response", 32'(rsp), 32'h0);
    bus(1'h1, 8'h0C, 32'h0000_0000);
    rd(8'h0C, PFTB_SRAM_BASE, "base after write");
    rd(8'h10, 32'h0000_0000, "unmapped data");
    check("unmapped response", 32'(rsp), 32'h2);
    // Buffer of 32 bytes at 0x100, tracing still off.
    bus(1'h1, 8'h00, 32'h0000_0100);
    bus(1'h1, 8'h04, 32'h0000_0001);
    i_src.send(32'h0000_0A00, 32'h0000_0B00, 1'h1, 1'h0, 1'b0);
    repeat (20) @(posedge sys_clk);
    rd(8'h00, 32'h0000_0100, "position while off");
    bus(1'h1, 8'h04, 32'h8000_0001);
    n_blk = 0;
    fork
      i_src.send(32'h0000_1234, 32'h0000_5678, 1'h1, 1'h0, 1'b0);
      begin
        @(posedge sys_clk);
        cpu_req  <= 1'h1;
        cpu_we   <= 1'h0;
        cpu_addr <= 13'h1F00;
        repeat (12) @(posedge sys_clk);
        cpu_req <= 1'h0;
      end
    join
    check("cpu wait cycles", n_blk, 32'h2);
    wait_pos(32'h0000_0108);
    cpu(1'h0, 13'h0100, 32'h0000_0000);
    check("word0", q, 32'h0000_1234);
    cpu(1'h0, 13'h0104, 32'h0000_0000);
    check("word1", q, 32'h0000_5678);
    // A sequential event must leave no packet behind.
    i_src.send(32'h0000_2000, 32'h0000_2004, 1'h0, 1'h0, 1'b0);
    @(posedge sys_clk);
    i_src.send(32'h0000_3000, 32'h0000_0010, 1'h0, 1'h1, 1'b0);
    wait_pos(32'h0000_0110);
    cpu(1'h0, 13'h0108, 32'h0000_0000);
    check("exception word0", q, 32'h0000_3000);
    cpu(1'h1, 13'h1F00, 32'hCAFE_0001);
    cpu(1'h0, 13'h1F00, 32'h0000_0000);
    check("cpu storage", q, 32'hCAFE_0001);
    // Eight packets streamed into a four packet ring.
    bus(1'h1, 8'h00, 32'h0000_0100);
    for (i = 0; i < 8; i++)
      i_src.send(32'h1000_0000 + i, 32'h2000_0000 + i, 1'h1, 1'h0, i < 7);
    // The position shows 0x104 after the first wrap too, so let the
    // queued packets drain before polling for the final value.
    repeat (20) @(posedge sys_clk);
    wait_pos(32'h0000_0104);
    check("fifo refused", 32'(i_src.n_refused != 0), 32'h1);
    cpu(1'h0, 13'h0100, 32'h0000_0000);
    check("overwritten word0", q, 32'h1000_0004);
    cpu(1'h0, 13'h011C, 32'h0000_0000);
    check("last word1", q, 32'h2000_0007);
    // Watermark at 0x110 with stop and halt selected.
    bus(1'h1, 8'h04, 32'h0000_0001);
    bus(1'h1, 8'h08, 32'h0000_0113);
    bus(1'h1, 8'h00, 32'h0000_0100);
    bus(1'h1, 8'h04, 32'h8000_0001);
    for (i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      i_src.send(32'h0000_4000 + i, 32'h0000_5000, 1'h1, 1'h0, 1'b0);
    end
    wait_pos(32'h0000_0110);
    @(posedge sys_clk);
    i_src.send(32'h0000_7777, 32'h0000_8888, 1'h1, 1'h0, 1'b0);
    repeat (20) @(posedge sys_clk);
    rd(8'h00, 32'h0000_0110, "position after stop");
    rd(8'h04, 32'h0000_0001, "master after stop");
    check("halt_req", 32'(halt_req), 32'h1);
    bus(1'h1, 8'h04, 32'h0000_0001);
    @(negedge sys_clk);
    check("halt_req cleared", 32'(halt_req), 32'h0);
    // Only the low byte lane may land, so the enable bit stays clear.
    avs_byteenable <= 4'h1;
    bus(1'h1, 8'h04, 32'hFFFF_FF03);
    avs_byteenable <= 4'hF;
    rd(8'h04, 32'h0000_0003, "master byte lane");
    tally_and_finish;
  end
endmodule
